// [core/dsp_ctrl_port.v]
// Control-port command decoder with coefficient and instruction RAMs
`include "dsp_ctrl_map.vh"
module dsp_ctrl_port #(
    parameter [39:0] DEFAULT_INSTR = 40'h00_0000_0000,
    parameter [6:0] DEV_ADDR = `DEV_ADDR_RST
) (
    input wire clk,
    input wire resetn,
    input wire spi_clk,
    input wire spi_mosi,
    input wire spi_latch_line,
    output reg spi_miso,
    output reg spi_miso_oe,
    input wire core_param_busy,
    input wire [9:0] core_param_addr,
    output reg [31:0] core_param_rdata,
    output reg host_param_access,
    input wire [9:0] core_prog_addr,
    output reg [39:0] core_prog_rdata,
    input wire [10:0] core_pc,
    input wire [23:0] cap_src0,
    input wire [23:0] cap_src1,
    input wire [23:0] cap_src2,
    input wire [23:0] cap_src3,
    output reg [15:0] core_control
);
    // Storage; validity maps give power-up contents
    reg [31:0] pram [0:1023];
    reg [39:0] iram [0:1023];
    reg [1023:0] pvalid_q;
    reg [1023:0] ivalid_q;
    reg [9:0] sld_addr_q [0:4];
    reg [27:0] sld_data_q [0:4];
    reg [4:0] sld_pend_q;
    reg [10:0] cap_idx_q [0:1];
    reg [1:0] cap_sel_q [0:1];
    reg [23:0] cap_val_q [0:1];
    // Link sampling
    wire sck_s2;
    wire mosi_s2;
    wire lat_s2;
    reg sck_last_q;
    // Framing
    reg [2:0] bit_q;
    reg [6:0] sh_q;
    reg [1:0] hcnt_q;
    reg sel_q;
    reg rw_q;
    reg [11:0] loc_q;
    reg [2:0] dcnt_q;
    reg [31:0] word_q;
    reg [39:0] tx_q;
    integer i;
    integer j;
    integer k;

    wire rise = sck_s2 & ~sck_last_q;
    wire fall = ~sck_s2 & sck_last_q;
    wire in_frame = ~lat_s2;
    wire [7:0] byte_in = {sh_q, mosi_s2};
    wire byte_done = in_frame & rise & (bit_q == 3'd7);
    wire hdr_last = byte_done & (hcnt_q == 2'd2);
    wire data_byte = byte_done & (hcnt_q == `HDR_BYTES) & sel_q;
    wire [11:0] loc_next = loc_q + 12'h001;

    function [2:0] word_len;
        input [11:0] a;
        input rd;
        begin
            if (a < `PROG_BASE)
                word_len = `LEN_PARAM;
            else if (a < `REG_BASE)
                word_len = `LEN_PROG;
            else if (a < `GPIO_BASE)
                word_len = `LEN_PARAM;
            else if (a < `SLD_DATA_BASE)
                word_len = `LEN_WIDE;
            else if (a < `SLD_ADDR_BASE)
                word_len = `LEN_SLD_DATA;
            else if (a < `CAP_BASE)
                word_len = `LEN_WIDE;
            else if (a < `CORE_CTRL)
                word_len = rd ? `LEN_CAP_RD : `LEN_WIDE;
            else if (a == `CORE_CTRL)
                word_len = `LEN_WIDE;
            else
                word_len = `LEN_BYTE;
        end
    endfunction

    wire [2:0] cur_len = word_len(loc_q, rw_q);
    wire word_end = data_byte & (dcnt_q + 3'd1 == cur_len);
    wire [39:0] wdata = {word_q, byte_in};
    wire wr_en = word_end & ~rw_q;
    wire host_pwr = wr_en & (loc_q < `PROG_BASE);
    wire [11:0] rd_addr = hdr_last ? {loc_q[11:8], byte_in} : loc_next;
    wire rd_load = in_frame & sel_q & rw_q & (hdr_last | word_end);
    wire [11:0] sld_doff = loc_q - `SLD_DATA_BASE;
    wire [11:0] sld_aoff = loc_q - `SLD_ADDR_BASE;
    wire [11:0] cap_off = loc_q - `CAP_BASE;
    wire [11:0] rcap_off = rd_addr - `CAP_BASE;

    // Read mux; no location reaches the audio data RAM
    reg [39:0] rd_word;
    always @* begin
        rd_word = 40'h00_0000_0000;
        if (rd_addr < `PROG_BASE) begin
            if (pvalid_q[rd_addr[9:0]])
                rd_word = {8'h00, pram[rd_addr[9:0]]};
        end else if (rd_addr < `REG_BASE) begin
            if (ivalid_q[rd_addr[9:0]])
                rd_word = iram[rd_addr[9:0]];
            else
                rd_word = DEFAULT_INSTR;
        end else if (rd_addr >= `CAP_BASE && rd_addr < `CORE_CTRL) begin
            rd_word = {16'h0000, cap_val_q[rcap_off[0]]};
        end else if (rd_addr == `CORE_CTRL) begin
            rd_word = {24'h00_0000, core_control};
        end
    end

    // Two-stage sampling of link pins
    link_sync #(
        .RST_VAL(1'b0)
    ) sck_sync (
        .clk(clk),
        .resetn(resetn),
        .pin(spi_clk),
        .sync_q(sck_s2)
    );
    link_sync #(
        .RST_VAL(1'b0)
    ) mosi_sync (
        .clk(clk),
        .resetn(resetn),
        .pin(spi_mosi),
        .sync_q(mosi_s2)
    );
    link_sync #(
        .RST_VAL(1'b1)
    ) latch_sync (
        .clk(clk),
        .resetn(resetn),
        .pin(spi_latch_line),
        .sync_q(lat_s2)
    );

    // Delayed link clock for edge detection
    always @(posedge clk) begin
        if (!resetn) begin
            sck_last_q <= 1'b0;
        end else begin
            sck_last_q <= sck_s2;
        end
    end

    // Frame decoder
    always @(posedge clk) begin
        if (!resetn || !in_frame) begin
            bit_q <= 3'd0;
            sh_q <= 7'h00;
            hcnt_q <= 2'd0;
            sel_q <= 1'b0;
            rw_q <= 1'b0;
            loc_q <= 12'h000;
            dcnt_q <= 3'd0;
            word_q <= 32'h0000_0000;
        end else if (rise) begin
            bit_q <= bit_q + 3'd1;
            sh_q <= byte_in[6:0];
            if (bit_q == 3'd7) begin
                if (hcnt_q != `HDR_BYTES) begin
                    hcnt_q <= hcnt_q + 2'd1;
                    case (hcnt_q)
                        2'd0: begin
                            sel_q <= (byte_in[7:1] == DEV_ADDR);
                            rw_q <= byte_in[0];
                        end
                        2'd1: loc_q[11:8] <= byte_in[3:0];
                        default: loc_q[7:0] <= byte_in;
                    endcase
                end else if (sel_q) begin
                    word_q <= wdata[31:0];
                    if (word_end) begin
                        dcnt_q <= 3'd0;
                        loc_q <= loc_next;
                        word_q <= 32'h0000_0000;
                    end else begin
                        dcnt_q <= dcnt_q + 3'd1;
                    end
                end
            end
        end
    end

    // Read shifter, changes on falling link edge
    always @(posedge clk) begin
        if (!resetn) begin
            tx_q <= 40'h00_0000_0000;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= in_frame & sel_q & rw_q & (hcnt_q == `HDR_BYTES);
            if (rd_load)
                tx_q <= rd_word << (6'd8 * (3'd5 - word_len(rd_addr, 1'b1)));
            else if (fall && in_frame) begin
                spi_miso <= tx_q[39];
                tx_q <= {tx_q[38:0], 1'b0};
            end
        end
    end

    // Coefficient RAM: host write first, then deferred copy
    reg sld_go;
    reg [2:0] sld_pick;
    always @* begin
        sld_go = 1'b0;
        sld_pick = 3'd0;
        for (i = `SLD_SLOTS - 1; i >= 0; i = i - 1) begin
            if (sld_pend_q[i]) begin
                sld_go = ~core_param_busy & ~host_pwr;
                sld_pick = i[2:0];
            end
        end
    end

    always @(posedge clk) begin
        if (host_pwr)
            pram[loc_q[9:0]] <= {4'h0, wdata[27:0]};
        else if (sld_go)
            pram[sld_addr_q[sld_pick]] <= {4'h0, sld_data_q[sld_pick]};
        if (wr_en && loc_q >= `PROG_BASE && loc_q < `REG_BASE)
            iram[loc_q[9:0]] <= wdata;
    end

    always @(posedge clk) begin
        if (!resetn) begin
            pvalid_q <= {1024{1'b0}};
            ivalid_q <= {1024{1'b0}};
            host_param_access <= 1'b0;
            core_param_rdata <= 32'h0000_0000;
            core_prog_rdata <= DEFAULT_INSTR;
        end else begin
            host_param_access <= host_pwr;
            if (host_pwr)
                pvalid_q[loc_q[9:0]] <= 1'b1;
            else if (sld_go)
                pvalid_q[sld_addr_q[sld_pick]] <= 1'b1;
            if (wr_en && loc_q >= `PROG_BASE && loc_q < `REG_BASE)
                ivalid_q[loc_q[9:0]] <= 1'b1;
            if (host_pwr)
                core_param_rdata <= 32'h0000_0000;
            else if (pvalid_q[core_param_addr])
                core_param_rdata <= pram[core_param_addr];
            else
                core_param_rdata <= 32'h0000_0000;
            if (ivalid_q[core_prog_addr])
                core_prog_rdata <= iram[core_prog_addr];
            else
                core_prog_rdata <= DEFAULT_INSTR;
        end
    end

    // Deferred slots; a new address write wins over the copy
    always @(posedge clk) begin
        if (!resetn) begin
            sld_pend_q <= 5'b0_0000;
            for (j = 0; j < `SLD_SLOTS; j = j + 1) begin
                sld_addr_q[j] <= 10'h000;
                sld_data_q[j] <= 28'h000_0000;
            end
        end else begin
            if (sld_go)
                sld_pend_q[sld_pick] <= 1'b0;
            if (wr_en && loc_q >= `SLD_DATA_BASE && loc_q < `SLD_ADDR_BASE)
                sld_data_q[sld_doff[2:0]] <= wdata[27:0];
            if (wr_en && loc_q >= `SLD_ADDR_BASE && loc_q < `CAP_BASE) begin
                sld_addr_q[sld_aoff[2:0]] <= wdata[9:0];
                sld_pend_q[sld_aoff[2:0]] <= 1'b1;
            end
        end
    end

    // Capture points and core control
    always @(posedge clk) begin
        if (!resetn) begin
            core_control <= `CORE_CTRL_RST;
            for (k = 0; k < `CAP_SLOTS; k = k + 1) begin
                cap_idx_q[k] <= 11'h000;
                cap_sel_q[k] <= 2'd0;
                cap_val_q[k] <= 24'h00_0000;
            end
        end else begin
            if (wr_en && loc_q == `CORE_CTRL)
                core_control <= wdata[15:0];
            for (k = 0; k < `CAP_SLOTS; k = k + 1) begin
                if (core_pc == cap_idx_q[k]) begin
                    case (cap_sel_q[k])
                        2'd0: cap_val_q[k] <= cap_src0;
                        2'd1: cap_val_q[k] <= cap_src1;
                        2'd2: cap_val_q[k] <= cap_src2;
                        default: cap_val_q[k] <= cap_src3;
                    endcase
                end
            end
            if (wr_en && loc_q >= `CAP_BASE && loc_q < `CORE_CTRL) begin
                cap_idx_q[cap_off[0]] <= wdata[12:2];
                cap_sel_q[cap_off[0]] <= wdata[1:0];
            end
        end
    end
endmodule // dsp_ctrl_port

// Two-flop synchroniser for one link pin
module link_sync #(
    parameter [0:0] RST_VAL = 1'b0
) (
    input wire clk,
    input wire resetn,
    input wire pin,
    output reg sync_q
);
    reg meta_q;

    always @(posedge clk) begin
        if (!resetn) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end
endmodule // link_sync

// [core/dsp_ctrl_map.vh]
// Locations, frame lengths and reset values of the control port
`ifndef DSP_CTRL_MAP_VH
`define DSP_CTRL_MAP_VH
`define PROG_BASE 12'h0400
`define REG_BASE 12'h0800
`define IFACE_BASE 12'h0800
`define GPIO_BASE 12'h0808
`define SLD_DATA_BASE 12'h0810
`define SLD_ADDR_BASE 12'h0815
`define SLD_SLOTS 5
`define CAP_BASE 12'h081A
`define CAP_SLOTS 2
`define CORE_CTRL 12'h081C
`define CORE_CTRL_RST 16'h0000
`define LEN_PARAM 3'd4
`define LEN_PROG 3'd5
`define LEN_WIDE 3'd2
`define LEN_BYTE 3'd1
`define LEN_CAP_RD 3'd3
`define LEN_SLD_DATA 3'd5
`define HDR_BYTES 2'd3
`define DEV_ADDR_RST 7'h34
`endif

// [verif/dsp_ctrl_port_checker.sv]
// Concurrent checks on the control port decoder pins
module dsp_ctrl_port_checker #(
    parameter [39:0] DEFAULT_INSTR = 40'h00_0000_0000
) (
    input wire clk,
    input wire resetn,
    input wire spi_latch_line,
    input wire spi_miso_oe,
    input wire core_param_busy,
    input wire [9:0] core_param_addr,
    input wire [31:0] core_param_rdata,
    input wire host_param_access,
    input wire [9:0] core_prog_addr,
    input wire [39:0] core_prog_rdata,
    input wire [15:0] core_control
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_RESET_VAL: assert property ($rose(resetn) |-> core_control == 16'h0000
        && core_prog_rdata == DEFAULT_INSTR) else $error("bad value after reset");
    AST_HPA_SPACING: assert property (host_param_access |=> !host_param_access [*8])
        else $error("coefficient writes too close");
    AST_HPA_FRAME: assert property (host_param_access |-> !spi_latch_line)
        else $error("coefficient write outside frame");
    AST_CTRL_HOLD: assert property (!$stable(core_control) |-> !spi_latch_line)
        else $error("control register changed outside frame");
    AST_PROG_HOLD: assert property (spi_latch_line && $past(spi_latch_line)
        && $stable(core_prog_addr) |=> $stable(core_prog_rdata))
        else $error("instruction word changed without write");
    AST_PARAM_HOLD: assert property (spi_latch_line && $past(spi_latch_line)
        && core_param_busy && $past(core_param_busy) && $stable(core_param_addr)
        |=> $stable(core_param_rdata)) else $error("coefficient changed while busy");
    AST_OE_START: assert property ($rose(spi_miso_oe) |-> !spi_latch_line)
        else $error("read drive outside frame");
    AST_OE_IDLE: assert property (spi_latch_line [*4] |-> !spi_miso_oe)
        else $error("read drive after frame end");
    COV_HPA: cover property (host_param_access);
    COV_OE: cover property ($rose(spi_miso_oe));
    COV_CTRL: cover property (!$stable(core_control));
endmodule // dsp_ctrl_port_checker

bind dsp_ctrl_port dsp_ctrl_port_checker #(.DEFAULT_INSTR(DEFAULT_INSTR)) chk_i (.clk(clk),
    .resetn(resetn), .spi_latch_line(spi_latch_line), .spi_miso_oe(spi_miso_oe),
    .core_param_busy(core_param_busy), .core_param_addr(core_param_addr),
    .core_param_rdata(core_param_rdata), .host_param_access(host_param_access),
    .core_prog_addr(core_prog_addr), .core_prog_rdata(core_prog_rdata),
    .core_control(core_control));

// [verif/spi_host.sv]
// Host microcontroller model driving the link
module spi_host (
    output logic sclk,
    output logic mosi,
    output logic latch_n,
    input wire miso
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        latch_n = 1'b1;
    end
    task automatic start();
        latch_n = 1'b0;
        #400;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #100 sclk = 1'b1;
            #90 rx[i] = miso;
            #10 sclk = 1'b0;
        end
    endtask
    task automatic stop();
        #400 latch_n = 1'b1;
        mosi = ~mosi;
        #800;
    endtask
endmodule // spi_host

// [verif/tb.sv]
// Self-checking bench for the control port decoder
`include "dsp_ctrl_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic core_param_busy = 1'b0;
    logic [9:0] core_param_addr = 10'h000;
    logic [9:0] core_prog_addr = 10'h000;
    logic [10:0] core_pc = 11'h123;
    logic [23:0] cap_src[4] = '{24'h11_1111, 24'h22_2222, 24'hAB_CDEF, 24'h33_3333};
    wire spi_clk, spi_mosi, spi_latch_line, spi_miso, spi_miso_oe, host_param_access;
    wire [31:0] core_param_rdata;
    wire [39:0] core_prog_rdata;
    wire [15:0] core_control;
    int errors = 0;
    int check_count = 0;
    int hpa_n = 0;
    logic [7:0] q[$];
    logic [7:0] rx[$];
    always #12.5 clk = ~clk;
    always @(negedge clk) if (host_param_access === 1'b1) hpa_n++;
    spi_host host (.sclk(spi_clk), .mosi(spi_mosi), .latch_n(spi_latch_line),
        .miso(spi_miso_oe ? spi_miso : 1'b1));
    dsp_ctrl_port dut (.clk(clk), .resetn(resetn), .spi_clk(spi_clk), .spi_mosi(spi_mosi),
        .spi_latch_line(spi_latch_line), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .core_param_busy(core_param_busy), .core_param_addr(core_param_addr),
        .core_param_rdata(core_param_rdata), .host_param_access(host_param_access),
        .core_prog_addr(core_prog_addr), .core_prog_rdata(core_prog_rdata), .core_pc(core_pc),
        .cap_src0(cap_src[0]), .cap_src1(cap_src[1]), .cap_src2(cap_src[2]),
        .cap_src3(cap_src[3]), .core_control(core_control));
    task automatic report_and_stop();
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic hdr(input logic [11:0] loc, input logic rd);
        q = {};
        q.push_back({`DEV_ADDR_RST, rd});
        q.push_back({4'h0, loc[11:8]});
        q.push_back(loc[7:0]);
    endtask
    task automatic put(input logic [39:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) q.push_back(v[8*i +: 8]);
    endtask
    task automatic send();
        logic [7:0] r;
        rx = {};
        host.start();
        foreach (q[i]) begin
            host.xfer(q[i], r);
            rx.push_back(r);
        end
        host.stop();
    endtask
    function automatic logic [39:0] rxv(input int n);
        rxv = '0;
        for (int i = 0; i < n; i++) rxv = {rxv[31:0], rx[3 + i]};
    endfunction
    task automatic core_rd(input logic [9:0] pa, input logic [9:0] ia);
        @(negedge clk);
        core_param_addr = pa;
        core_prog_addr = ia;
        repeat (3) @(negedge clk);
    endtask
    initial begin
        #1_000_000;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        core_rd(10'h3FF, 10'h000);
        chk(core_control, 40'h0000);
        chk(core_param_rdata, 40'h0000);
        chk(core_prog_rdata, 40'h0000);
        hdr(`CORE_CTRL, 1'b0);
        q[0] = 8'h6A;
        put(40'hA5C3, 2);
        send();
        chk(core_control, 40'h0000);
        hdr(`CORE_CTRL, 1'b0);
        put(40'hA5C3, 2);
        send();
        chk(core_control, 40'hA5C3);
        hdr(`CORE_CTRL, 1'b0);
        put(40'h0000, 2);
        send();
        chk(core_control, 40'h0000);
        hdr(12'h3FF, 1'b0);
        put(40'h0080_0000, 4);
        put(40'hA1_B2C3_D4E5, 5);
        send();
        core_rd(10'h3FF, 10'h000);
        chk(core_param_rdata, 40'h0080_0000);
        chk(core_prog_rdata, 40'hA1_B2C3_D4E5);
        chk(40'(hpa_n), 40'h0001);
        hdr(12'h3FF, 1'b1);
        put(40'h0000, 4);
        send();
        chk(rxv(4), 40'h0080_0000);
        @(negedge clk) core_param_busy = 1'b1;
        hdr(`SLD_DATA_BASE, 1'b0);
        put(40'h00_0123_4567, 5);
        send();
        hdr(`SLD_ADDR_BASE, 1'b0);
        put(40'h0007, 2);
        send();
        core_rd(10'h007, 10'h000);
        chk(core_param_rdata, 40'h0000);
        @(negedge clk) core_param_busy = 1'b0;
        core_rd(10'h007, 10'h000);
        chk(core_param_rdata, 40'h0123_4567);
        hdr(`CAP_BASE, 1'b0);
        put(40'h048E, 2);
        send();
        hdr(`CAP_BASE, 1'b1);
        put(40'h0000, 3);
        send();
        chk(rxv(3), 40'hAB_CDEF);
        core_pc = 11'h124;
        cap_src[2] = 24'h44_4444;
        send();
        chk(rxv(3), 40'hAB_CDEF);
        report_and_stop();
    end
endmodule // tb
